// ### core/timer_status_pkg.sv
// Purpose: Constants and types shared by the timer status and flag logic.
// Assumes: Byte-wide register port, one 50 MHz clock.
// Notes: Offsets are byte addresses on the plain register port.
package timer_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B_CLR = 8'h04;
  localparam logic [7:0] OFS_CTRL_B_SET = 8'h05;
  localparam logic [7:0] OFS_IRQ_MASK_CLR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK_SET = 8'h0d;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0e;
  localparam logic [7:0] OFS_STATUS = 8'h0f;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_PERIOD = 8'h14;
  localparam logic [7:0] OFS_CAPTURE = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRLA_ENABLE_BIT = 1;
  localparam int CTRLA_MODE32_BIT = 2;
  localparam int CTRLA_PRESC_LSB = 4;
  localparam int CTRLB_DIR_BIT = 0;
  localparam int CTRLB_SINGLE_BIT = 2;
  localparam int CTRLB_CMD_LSB = 6;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RETRIGGER = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_ERR_BIT = 1;
  localparam int FLAG_CAP_BIT = 4;
  localparam logic [7:0] FLAG_IMPL = 8'h13;
  localparam int STAT_SYNC_BIT = 7;
  localparam int STAT_SLAVE_BIT = 4;
  localparam int STAT_STOP_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h08;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_TIME_NS = 60;
  localparam int SYNC_CYCLES_I = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SYNC_CYCLES = 4'(SYNC_CYCLES_I);

  // Run state, Gray coded along off -> count -> halt
  typedef enum logic [1:0] {
    RUN_OFF = 2'b00,
    RUN_COUNT = 2'b01,
    RUN_HALT = 2'b11
  } run_state_t;

endpackage

// ### core/timer_status_and_flags.sv
// Purpose: Eight-bit timer with capture, overflow flags and status register.
// Assumes: Inputs synchronous to clk_sys; capture_in is a one-cycle pulse.
// Notes: Enable, commands and count writes cross through a short sync delay.
`timescale 1ns/1ps
`default_nettype none

module timer_status_and_flags
#(
  parameter bit IS_ODD_TIMER = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [timer_status_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer_status_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [timer_status_pkg::DATA_W-1:0] reg_rdata,
  input wire logic capture_in,
  input wire logic pair_master_mode32,
  output logic mode32_out,
  output logic irq
);
  import timer_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  run_state_t state_r;
  logic [7:0] ctrl_a_r;
  logic single_run_setting_r;
  logic dir_down_r;
  logic [7:0] irq_mask_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] status_r;
  logic [7:0] count_r;
  logic [7:0] period_r;
  logic [7:0] capture_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic mode32_r;
  logic [6:0] div_r;
  logic [6:0] div_mask;
  logic counter_prescaled_clock;
  logic [3:0] sync_cnt_r;
  logic domain_sync_pending;
  logic sync_done;
  logic pend_en_valid_r;
  logic pend_en_r;
  logic [1:0] pend_cmd_r;
  logic pend_count_valid_r;
  logic [7:0] pend_count_r;
  logic ovf_seen_r;
  logic wrap_now;
  logic ovf_apply;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic wr_ctrl_a;
  logic wr_ctrlb_set;
  logic wr_count;
  logic sync_write;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_ctrl_a = reg_wr && (reg_addr == OFS_CTRL_A);
  assign wr_ctrlb_set = reg_wr && (reg_addr == OFS_CTRL_B_SET);
  assign wr_count = reg_wr && (reg_addr == OFS_COUNT);
  // Writes that must cross into the counter domain; refused while one is in flight
  assign sync_write = (wr_ctrl_a || wr_count || wr_ctrlb_set) && !domain_sync_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Control A: enable and mode32 stored at once, enable applied after sync
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ctrl_a_r <= ZERO8;
    else if (wr_ctrl_a && !domain_sync_pending)
      ctrl_a_r <= reg_wdata;
  end

  // Mode32 goes to the paired odd timer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      mode32_r <= 1'b0;
    else
      mode32_r <= ctrl_a_r[CTRLA_MODE32_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control B: direction and single-run, set and clear views
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      dir_down_r <= 1'b0;
      single_run_setting_r <= 1'b0;
    end
    else if (reg_wr && (reg_addr == OFS_CTRL_B_SET))
    begin
      if (reg_wdata[CTRLB_DIR_BIT])
        dir_down_r <= 1'b1;
      if (reg_wdata[CTRLB_SINGLE_BIT])
        single_run_setting_r <= 1'b1;
    end
    else if (reg_wr && (reg_addr == OFS_CTRL_B_CLR))
    begin
      if (reg_wdata[CTRLB_DIR_BIT])
        dir_down_r <= 1'b0;
      if (reg_wdata[CTRLB_SINGLE_BIT])
        single_run_setting_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync delay: busy from the write until the crossing completes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sync_cnt_r <= 4'h0;
    else if (sync_write)
      sync_cnt_r <= SYNC_CYCLES;
    else if (sync_cnt_r != 4'h0)
      sync_cnt_r <= sync_cnt_r - 4'h1;
  end

  assign domain_sync_pending = (sync_cnt_r != 4'h0);
  assign sync_done = (sync_cnt_r == 4'h1);

  // Values held until the crossing completes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_en_valid_r <= 1'b0;
      pend_en_r <= 1'b0;
      pend_cmd_r <= CMD_NONE;
      pend_count_valid_r <= 1'b0;
      pend_count_r <= COUNT_RST;
    end
    else if (sync_write)
    begin
      pend_en_valid_r <= wr_ctrl_a;
      pend_en_r <= reg_wdata[CTRLA_ENABLE_BIT];
      pend_cmd_r <= wr_ctrlb_set ? reg_wdata[CTRLB_CMD_LSB+:2] : CMD_NONE;
      pend_count_valid_r <= wr_count;
      pend_count_r <= reg_wdata;
    end
    else if (sync_done)
    begin
      pend_en_valid_r <= 1'b0;
      pend_cmd_r <= CMD_NONE;
      pend_count_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: divide by two to the power of the select field
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      div_r <= 7'h00;
    else if (state_r == RUN_OFF)
      div_r <= 7'h00;
    else
      div_r <= div_r + 7'h01;
  end

  assign div_mask = 7'((8'h01 << ctrl_a_r[CTRLA_PRESC_LSB+:3]) - 8'h01);
  assign counter_prescaled_clock = (state_r != RUN_OFF) && ((div_r & div_mask) == div_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Run state machine
  assign wrap_now = counter_prescaled_clock && (state_r == RUN_COUNT) &&
                    (dir_down_r ? (count_r == ZERO8) : (count_r == period_r));

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= RUN_OFF;
    end
    else
    begin
      case (state_r)
        RUN_OFF:
        begin
          if (sync_done && pend_en_valid_r && pend_en_r)
            state_r <= RUN_COUNT;
        end
        RUN_COUNT:
        begin
          if (sync_done && pend_en_valid_r && !pend_en_r)
            state_r <= RUN_OFF;
          else if (sync_done && (pend_cmd_r == CMD_STOP))
            state_r <= RUN_HALT;
          else if (wrap_now && single_run_setting_r)
            state_r <= RUN_HALT;
        end
        RUN_HALT:
        begin
          if (sync_done && pend_en_valid_r && !pend_en_r)
            state_r <= RUN_OFF;
          else if (sync_done && (pend_cmd_r == CMD_RETRIGGER))
            state_r <= RUN_COUNT;
        end
        default:
        begin
          state_r <= RUN_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter value
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      count_r <= COUNT_RST;
    end
    else if (sync_done && pend_count_valid_r)
    begin
      count_r <= pend_count_r;
    end
    else if (sync_done && (pend_cmd_r == CMD_RETRIGGER))
    begin
      count_r <= dir_down_r ? period_r : ZERO8;
    end
    else if (wrap_now)
    begin
      count_r <= dir_down_r ? period_r : ZERO8;
    end
    else if (counter_prescaled_clock && (state_r == RUN_COUNT))
    begin
      count_r <= dir_down_r ? count_r - 8'h01 : count_r + 8'h01;
    end
  end

  // Period register, written directly
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      period_r <= PERIOD_RST;
    else if (reg_wr && (reg_addr == OFS_PERIOD))
      period_r <= reg_wdata;
  end

  // Capture register takes the count on a capture pulse while the capture flag is clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      capture_r <= ZERO8;
    else if (capture_in && !flags_r[FLAG_CAP_BIT])
      capture_r <= count_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow seen, turned into a flag at the following counter tick
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ovf_seen_r <= 1'b0;
    else if (wrap_now)
      ovf_seen_r <= 1'b1;
    else if (ovf_apply)
      ovf_seen_r <= 1'b0;
  end

  // A halted timer keeps ticking the prescaler; a disabled one applies at once
  assign ovf_apply = ovf_seen_r && (counter_prescaled_clock || (state_r == RUN_OFF));

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: write one clears, set wins over clear
  always_comb
  begin
    set_vec = ZERO8;
    set_vec[FLAG_OVF_BIT] = ovf_apply;
    set_vec[FLAG_CAP_BIT] = capture_in && !flags_r[FLAG_CAP_BIT];
    set_vec[FLAG_ERR_BIT] = capture_in && flags_r[FLAG_CAP_BIT];
    clr_vec = (reg_wr && (reg_addr == OFS_IRQ_FLAGS)) ? reg_wdata : ZERO8;
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & FLAG_IMPL;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      flags_r <= ZERO8;
    else
      flags_r <= flags_nxt;
  end

  // Interrupt mask, set and clear views
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_mask_r <= ZERO8;
    else if (reg_wr && (reg_addr == OFS_IRQ_MASK_SET))
      irq_mask_r <= (irq_mask_r | reg_wdata) & FLAG_IMPL;
    else if (reg_wr && (reg_addr == OFS_IRQ_MASK_CLR))
      irq_mask_r <= irq_mask_r & ~reg_wdata;
  end

  // Level interrupt while any unmasked flag is set
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_r <= 1'b0;
    else
      irq_r <= |(flags_r & irq_mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      status_r <= STATUS_RST;
    end
    else
    begin
      status_r <= ZERO8;
      status_r[STAT_SYNC_BIT] <= domain_sync_pending;
      status_r[STAT_SLAVE_BIT] <= IS_ODD_TIMER && pair_master_mode32;
      status_r[STAT_STOP_BIT] <= (state_r != RUN_COUNT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r <= ZERO8;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL_A: rdata_r <= ctrl_a_r;
        OFS_CTRL_B_CLR, OFS_CTRL_B_SET:
          rdata_r <= {5'h00, single_run_setting_r, 1'b0, dir_down_r};
        OFS_IRQ_MASK_CLR, OFS_IRQ_MASK_SET: rdata_r <= irq_mask_r;
        OFS_IRQ_FLAGS: rdata_r <= flags_r;
        OFS_STATUS: rdata_r <= status_r;
        OFS_COUNT: rdata_r <= count_r;
        OFS_PERIOD: rdata_r <= period_r;
        OFS_CAPTURE: rdata_r <= capture_r;
        default: rdata_r <= ZERO8;
      endcase
    end
    else
    begin
      rdata_r <= ZERO8;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign mode32_out = mode32_r;

endmodule

`default_nettype wire

// ### tb/timer_status_and_flags_properties.sv
// Purpose: Port-level assertions for the timer status and flags.
// Assumes: Sees the top ports only; attached by the bind below.
// Notes: Helper flags track crossing writes and the enable bit.
`timescale 1ns/1ps
`default_nettype none

module timer_status_and_flags_properties
#(
  parameter bit IS_ODD_TIMER = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic capture_in,
  input wire logic pair_master_mode32,
  input wire logic mode32_out,
  input wire logic irq
);
  import timer_status_pkg::*;
  logic touched_r;
  logic en_r;
  logic xw;

  // Writes that start a crossing
  assign xw = reg_wr && (reg_addr == OFS_CTRL_A || reg_addr == OFS_CTRL_B_SET
    || reg_addr == OFS_COUNT);

  // Any crossing write since reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      touched_r <= 1'b0;
    else if (xw)
      touched_r <= 1'b1;
  end

  // Last enable value written
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      en_r <= 1'b0;
    else if (reg_wr && reg_addr == OFS_CTRL_A)
      en_r <= reg_wdata[CTRLA_ENABLE_BIT];
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence stat_rd;
    reg_rd && reg_addr == OFS_STATUS;
  endsequence
  sequence count_wr;
    reg_wr && reg_addr == OFS_COUNT;
  endsequence

  read_idle_a:
    assert property (!reg_rd |=> reg_rdata == ZERO8) else $error("read data not idle");
  status_spare_a:
    assert property (stat_rd |=> (reg_rdata & 8'h67) == ZERO8) else $error("spare bits set");
  status_reset_a:
    assert property (reg_rd && reg_addr == OFS_STATUS && !touched_r && !pair_master_mode32
      && !$past(pair_master_mode32) |=> reg_rdata == STATUS_RST) else $error("status reset");
  slave_bit_a:
    assert property (stat_rd ##0 $stable(pair_master_mode32) |=> reg_rdata[STAT_SLAVE_BIT]
      == (IS_ODD_TIMER && $past(pair_master_mode32))) else $error("slave bit wrong");
  sync_set_a:
    assert property (count_wr ##2 stat_rd |=> reg_rdata[STAT_SYNC_BIT])
      else $error("sync pending not set");
  sync_clear_a:
    assert property (count_wr ##1 (!xw throughout (1'b1 ##[8:16] stat_rd))
      |=> !reg_rdata[STAT_SYNC_BIT]) else $error("sync pending stuck");
  mask_off_a:
    assert property (reg_wr && reg_addr == OFS_IRQ_MASK_CLR && reg_wdata == 8'hff
      |=> ##1 !irq) else $error("irq while masked");
  flags_clear_a:
    assert property (reg_wr && reg_addr == OFS_IRQ_FLAGS && reg_wdata == FLAG_IMPL
      && !capture_in && !en_r ##1 !capture_in |=> !irq) else $error("irq after clear");
endmodule

bind timer_status_and_flags timer_status_and_flags_properties #(.IS_ODD_TIMER(IS_ODD_TIMER))
  props_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_in(capture_in),
  .pair_master_mode32(pair_master_mode32), .mode32_out(mode32_out), .irq(irq));
`default_nettype wire

// ### tb/timer_status_and_flags_tb.sv
// Purpose: Self-checking bench for the timer status and flags.
// Assumes: One 50 MHz clock; bench drives every input port.
// Notes: A small flag and mask model predicts reads and irq.
`timescale 1ns/1ps
`default_nettype none

module timer_status_and_flags_tb;
  import timer_status_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic capture_in = 1'b0;
  logic pair_master_mode32 = 1'b0;
  logic mode32_out;
  logic irq;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 20096;
  int flags_m = 0;
  int mask_m = 0;
  logic [7:0] v;

  timer_status_and_flags #(.IS_ODD_TIMER(1'b1)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_in(capture_in),
    .pair_master_mode32(pair_master_mode32), .mode32_out(mode32_out), .irq(irq));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Write cycle, optional capture beside it; model follows
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic c = 1'b0);
    int s;
    s = 0;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    capture_in <= c;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    capture_in <= 1'b0;
    if (c)
      s = flags_m[FLAG_CAP_BIT] ? 2 : 16;
    if (a == OFS_IRQ_FLAGS)
      flags_m &= ~int'(d);
    flags_m |= s;
    if (a == OFS_IRQ_MASK_SET)
      mask_m |= int'(d);
    if (a == OFS_IRQ_MASK_CLR)
      mask_m &= ~int'(d);
  endtask

  // Write, then let the crossing settle
  task automatic xwr(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (8) @(posedge clk_sys);
  endtask

  // Read cycle; data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(name, reg_rdata, exp);
  endtask

  // Interrupt level against the model
  task automatic irq_chk;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("irq", {7'h00, irq}, {7'h00, (flags_m & mask_m) != 0});
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(OFS_STATUS, STATUS_RST, "status");
    rd(OFS_COUNT, COUNT_RST, "count");
    rd(8'h30, 8'h00, "unmapped");
    wr(OFS_IRQ_MASK_SET, FLAG_IMPL);
    wr(8'h30, 8'h5a, 1'b1);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "capture flag");
    wr(8'h30, 8'h5a, 1'b1);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "error flag");
    irq_chk();
    wr(OFS_IRQ_FLAGS, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "zero write");
    wr(OFS_IRQ_FLAGS, 8'h02, 1'b1);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "set beats clear");
    wr(OFS_IRQ_FLAGS, 8'h02);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "error cleared");
    wr(OFS_IRQ_MASK_CLR, 8'hff);
    irq_chk();
    wr(OFS_IRQ_MASK_SET, FLAG_IMPL);
    wr(OFS_IRQ_FLAGS, FLAG_IMPL);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "all cleared");
    v = 8'($random(seed));
    wr(OFS_COUNT, v);
    rd(OFS_STATUS, 8'h88, "sync pending");
    repeat (8) @(posedge clk_sys);
    rd(OFS_STATUS, STATUS_RST, "sync done");
    rd(OFS_COUNT, v, "count value");
    @(posedge clk_sys);
    pair_master_mode32 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(OFS_STATUS, 8'h18, "slave");
    xwr(OFS_COUNT, 8'h00);
    wr(OFS_PERIOD, 8'h03);
    xwr(OFS_CTRL_B_SET, 8'h04);
    xwr(OFS_CTRL_A, 8'h02);
    repeat (20) @(posedge clk_sys);
    flags_m |= 1;
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "wrap flag");
    irq_chk();
    rd(OFS_STATUS, 8'h18, "single-run halt");
    wr(OFS_IRQ_FLAGS, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "wrap kept");
    wr(OFS_IRQ_FLAGS, 8'h01);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "wrap cleared");
    wr(OFS_CTRL_B_CLR, 8'h04);
    xwr(OFS_CTRL_B_SET, {CMD_RETRIGGER, 6'h00});
    flags_m |= 1;
    rd(OFS_STATUS, 8'h10, "running");
    xwr(OFS_CTRL_B_SET, {CMD_STOP, 6'h00});
    rd(OFS_STATUS, 8'h18, "stop command");
    xwr(OFS_CTRL_B_SET, {CMD_RETRIGGER, 6'h00});
    xwr(OFS_CTRL_A, 8'h00);
    rd(OFS_STATUS, 8'h18, "disabled");
    // Down count, single run, divide by two: underflow flag waits for the next tick
    xwr(OFS_CTRL_B_SET, 8'h05);
    xwr(OFS_COUNT, 8'h02);
    wr(OFS_IRQ_FLAGS, FLAG_IMPL);
    xwr(OFS_CTRL_A, 8'h16);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "wrap not yet");
    flags_m |= 1;
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "wrap next tick");
    rd(OFS_COUNT, 8'h03, "reload");
    rd(OFS_STATUS, 8'h18, "single-run underflow");
    chk("mode32", {7'h00, mode32_out}, 8'h01);
    xwr(OFS_CTRL_A, 8'h00);
    wr(OFS_IRQ_FLAGS, FLAG_IMPL);
    rd(OFS_IRQ_FLAGS, 8'(flags_m), "final clear");
    irq_chk();
    wrap_up();
  end

  // Cycle ceiling against a hang
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
